/* core/t1lij_top.sv */
// top of the t1 line interface control and jitter attenuator logic
// assumes a plain register port and tx_clock_in, line inputs synchronous to mclk
//
// Strobed register access was decided locally.
`timescale 1ns/10ps
module t1lij_top
  import t1lij_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [7:0] rdata,
  output logic irq,
  input wire logic rx_line_pos,
  input wire logic rx_line_neg,
  input wire logic tx_clock_in,
  input wire logic tx_data_in,
  input wire logic tx_line_clock_en,
  output logic tx_line_pos_o,
  output logic tx_line_pos_oe,
  output logic tx_line_neg_o,
  output logic tx_line_neg_oe,
  output logic [2:0] build_out_code,
  output logic rx_gain_limit,
  output logic recovered_clock_out,
  output logic rx_data_out,
  output logic tx_line_clock,
  output logic rx_carrier_loss
);
  import t1lij_pkg::*;
  logic [7:0] ctl_r, ctl_nxt, stat_r, stat_nxt, mask_r, mask_nxt, rdata_r, rdata_nxt;
  logic trip_r, trip_nxt, clos_r, clos_nxt, txc_r, txc_nxt;
  logic tlc_r, tlc_nxt, ami_r, ami_nxt, tx_mark;
  logic [4:0] div_r, div_nxt, dcnt_r, dcnt_nxt;
  logic [3:0] pre_r, pre_nxt;
  logic sm_clk_r, sm_clk_nxt, rd_pulse_r, rd_pulse_nxt;
  logic ovs_tick, rec_clk, rec_data, rec_bit, carrier_lost;
  logic ja_on, ja_rx, wr_en, wr_bit, rd_bit, tx_edge, excess_hi, excess_lo, off_nominal;
  logic [7:0] fill, depth, margin;
  t1lij_bo_t build_out_sel;

  function automatic logic [7:0] depth_of(input logic sel);
    depth_of = sel ? T1LIJ_DEPTH_SMALL : T1LIJ_DEPTH_BIG;
  endfunction

  // ----------------------------------------------------------------
  // recovery and fifo
  // ----------------------------------------------------------------
  t1lij_recovery u_rec (
    .mclk(mclk),
    .rst_n(rst_n),
    .ovs_tick(ovs_tick),
    .rx_line_pos(rx_line_pos),
    .rx_line_neg(rx_line_neg),
    .rec_clk(rec_clk),
    .rec_data(rec_data),
    .rec_bit(rec_bit),
    .carrier_lost(carrier_lost)
  );
  t1lij_fifo u_fifo (
    .mclk(mclk),
    .rst_n(rst_n),
    .wr_en(wr_en),
    .wr_bit(wr_bit),
    .rd_en(rd_pulse_r),
    .rd_bit(rd_bit),
    .fill(fill)
  );

  // ----------------------------------------------------------------
  // control decode
  // ----------------------------------------------------------------
  always_comb
  begin
    build_out_sel = t1lij_bo_t'(ctl_r[T1LIJ_BO_MSB:T1LIJ_BO_LSB]);
    ja_on = !ctl_r[T1LIJ_DIS_BIT];
    ja_rx = !ctl_r[T1LIJ_PATH_BIT];
    depth = depth_of(ctl_r[T1LIJ_DEPTH_BIT]);
    margin = ctl_r[T1LIJ_DEPTH_BIT] ? T1LIJ_MARGIN_SMALL : T1LIJ_MARGIN_BIG;
    ovs_tick = (pre_r == 4'h0);
    tx_edge = tx_clock_in & !txc_r;
    wr_en = ja_on && (ja_rx ? rec_bit : tx_edge);
    wr_bit = ja_rx ? rec_data : tx_data_in;
    excess_hi = fill >= depth - margin;
    excess_lo = fill < margin;
    off_nominal = ja_on && (excess_hi || excess_lo);
  end

  // ----------------------------------------------------------------
  // smoothed clock divider
  // ----------------------------------------------------------------
  always_comb
  begin
    pre_nxt = pre_r + 4'h1;
    txc_nxt = tx_clock_in;
    div_nxt = div_r;
    dcnt_nxt = dcnt_r + 5'd1;
    sm_clk_nxt = sm_clk_r;
    rd_pulse_nxt = 1'b0;
    trip_nxt = 1'b0;
    if (dcnt_r >= div_r - 5'd1)
    begin
      dcnt_nxt = 5'd0;
      rd_pulse_nxt = ja_on;
      if (!off_nominal)
        div_nxt = T1LIJ_DIV_NOM;
      else if (excess_hi)
        div_nxt = T1LIJ_DIV_FAST;
      else
        div_nxt = T1LIJ_DIV_SLOW;
    end
    sm_clk_nxt = (dcnt_nxt < {1'b0, div_nxt[4:1]});
    trip_nxt = (div_r != T1LIJ_DIV_NOM);
  end
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pre_r <= 4'h0;
      txc_r <= 1'b0;
      div_r <= T1LIJ_DIV_NOM;
      dcnt_r <= 5'd0;
      sm_clk_r <= 1'b0;
      rd_pulse_r <= 1'b0;
      trip_r <= 1'b0;
    end
    else
    begin
      pre_r <= pre_nxt;
      txc_r <= txc_nxt;
      div_r <= div_nxt;
      dcnt_r <= dcnt_nxt;
      sm_clk_r <= sm_clk_nxt;
      rd_pulse_r <= rd_pulse_nxt;
      trip_r <= trip_nxt;
    end
  end

  // ----------------------------------------------------------------
  // registers and interrupt
  // ----------------------------------------------------------------
  always_comb
  begin
    ctl_nxt = ctl_r;
    mask_nxt = mask_r;
    stat_nxt = stat_r;
    clos_nxt = carrier_lost;
    rdata_nxt = 8'h00;
    if (wr_stb && addr == T1LIJ_ADDR_LINE_CTL)
      ctl_nxt = wdata;
    if (wr_stb && addr == T1LIJ_ADDR_IMASK)
      mask_nxt = wdata;
    if (wr_stb && addr == T1LIJ_ADDR_ISTAT)
      stat_nxt = stat_r & ~wdata;
    if (trip_r)
      stat_nxt[T1LIJ_TRIP_BIT] = 1'b1;
    if (carrier_lost && !clos_r)
      stat_nxt[T1LIJ_CLOS_BIT] = 1'b1;
    if (rd_stb)
    begin
      case (addr)
        T1LIJ_ADDR_LINE_CTL: rdata_nxt = ctl_r;
        T1LIJ_ADDR_RX_INFO: rdata_nxt = {2'b00, trip_r, 4'h0, carrier_lost};
        T1LIJ_ADDR_ISTAT: rdata_nxt = stat_r;
        T1LIJ_ADDR_IMASK: rdata_nxt = mask_r;
        default: rdata_nxt = 8'h00;
      endcase
    end
  end
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctl_r <= T1LIJ_LINE_CTL_RST;
      mask_r <= T1LIJ_IMASK_RST;
      stat_r <= 8'h00;
      clos_r <= 1'b0;
      rdata_r <= 8'h00;
    end
    else
    begin
      ctl_r <= ctl_nxt;
      mask_r <= mask_nxt;
      stat_r <= stat_nxt;
      clos_r <= clos_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ----------------------------------------------------------------
  // transmit mark polarity
  // ----------------------------------------------------------------
  always_comb
  begin
    tlc_nxt = tx_line_clock;
    ami_nxt = ami_r;
    if (tx_line_clock && !tlc_r && tx_mark)
      ami_nxt = !ami_r;
  end
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tlc_r <= 1'b0;
      ami_r <= 1'b0;
    end
    else
    begin
      tlc_r <= tlc_nxt;
      ami_r <= ami_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign rdata = rdata_r;
  assign irq = |(stat_r & mask_r);
  assign build_out_code = build_out_sel;
  assign rx_gain_limit = ctl_r[T1LIJ_GAIN_BIT];
  assign rx_carrier_loss = carrier_lost;
  assign recovered_clock_out = carrier_lost ? pre_r[3] : ((ja_on && ja_rx) ? sm_clk_r : rec_clk);
  assign rx_data_out = (ja_on && ja_rx) ? rd_bit : rec_data;
  assign tx_line_clock = (ja_on && !ja_rx) ? sm_clk_r : (tx_clock_in & tx_line_clock_en);
  assign tx_mark = (ja_on && !ja_rx) ? rd_bit : tx_data_in;
  assign tx_line_pos_oe = !ctl_r[T1LIJ_PDN_BIT];
  assign tx_line_neg_oe = !ctl_r[T1LIJ_PDN_BIT];
  assign tx_line_pos_o = tx_mark & !ami_r & tx_line_pos_oe;
  assign tx_line_neg_o = tx_mark & ami_r & tx_line_neg_oe;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence s_wrap_full;
    dcnt_r >= div_r - 5'd1 && ja_on && excess_hi;
  endsequence
  sequence s_wrap_empty;
    dcnt_r >= div_r - 5'd1 && ja_on && excess_lo && !excess_hi;
  endsequence

  a_pdn_tristate: assert property (@(posedge mclk) disable iff (!rst_n)
    ctl_r[T1LIJ_PDN_BIT] |-> !tx_line_pos_oe && !tx_line_neg_oe)
    else $error("tx driven in power down");
  a_ami_exclusive: assert property (@(posedge mclk) disable iff (!rst_n)
    !(tx_line_pos_o && tx_line_neg_o))
    else $error("both tx lines marked");
  a_ctl_write: assert property (@(posedge mclk) disable iff (!rst_n)
    wr_stb && addr == T1LIJ_ADDR_LINE_CTL |=> ctl_r == $past(wdata))
    else $error("control write lost");
  a_build_out_code: assert property (@(posedge mclk) disable iff (!rst_n)
    build_out_code == ctl_r[7:5])
    else $error("build-out code mismatch");
  a_div_trip_flag: assert property (@(posedge mclk) disable iff (!rst_n)
    div_r != T1LIJ_DIV_NOM |=> trip_r)
    else $error("trip flag missing");
  a_trip_sticky: assert property (@(posedge mclk) disable iff (!rst_n)
    trip_r |=> stat_r[T1LIJ_TRIP_BIT])
    else $error("trip status not set");
  a_div_legal: assert property (@(posedge mclk) disable iff (!rst_n)
    div_r == T1LIJ_DIV_NOM || div_r == T1LIJ_DIV_FAST || div_r == T1LIJ_DIV_SLOW)
    else $error("bad divide");
  a_fast_on_full: assert property (@(posedge mclk) disable iff (!rst_n)
    s_wrap_full |=> div_r == T1LIJ_DIV_FAST)
    else $error("no fast divide when full");
  a_slow_on_empty: assert property (@(posedge mclk) disable iff (!rst_n)
    s_wrap_empty |=> div_r == T1LIJ_DIV_SLOW)
    else $error("no slow divide when empty");
  a_depth_small: assert property (@(posedge mclk) disable iff (!rst_n)
    ctl_r[T1LIJ_DEPTH_BIT] |-> depth == T1LIJ_DEPTH_SMALL)
    else $error("depth select wrong");
  a_disable_nodiv: assert property (@(posedge mclk) disable iff (!rst_n)
    !ja_on && dcnt_r == 5'd0 |-> div_r == T1LIJ_DIV_NOM || $past(ja_on))
    else $error("divide while bypassed");
  a_bypass_rx_data: assert property (@(posedge mclk) disable iff (!rst_n)
    !ja_on |-> rx_data_out == rec_data)
    else $error("bypass data path wrong");
  a_bypass_no_read: assert property (@(posedge mclk) disable iff (!rst_n)
    !ja_on |=> !rd_pulse_r)
    else $error("fifo read while bypassed");
  a_rx_path_clock: assert property (@(posedge mclk) disable iff (!rst_n)
    ja_on && ja_rx && !carrier_lost |-> recovered_clock_out == sm_clk_r)
    else $error("receive clock not smoothed");
  a_tx_path_clock: assert property (@(posedge mclk) disable iff (!rst_n)
    ja_on && !ja_rx |-> tx_line_clock == sm_clk_r)
    else $error("transmit clock not smoothed");
  a_loss_clock: assert property (@(posedge mclk) disable iff (!rst_n)
    carrier_lost |-> recovered_clock_out == pre_r[3])
    else $error("loss clock source");
  a_gain_pass: assert property (@(posedge mclk) disable iff (!rst_n)
    rx_gain_limit == ctl_r[T1LIJ_GAIN_BIT])
    else $error("gain limit mismatch");
  a_read_data: assert property (@(posedge mclk) disable iff (!rst_n)
    rd_stb && addr == T1LIJ_ADDR_LINE_CTL |=> rdata == $past(ctl_r))
    else $error("read data wrong");
endmodule

/* core/t1lij_pkg.sv */
// package of constants for the t1 line interface and jitter control block
// assumes a single mclk domain at 250 MHz and a plain register port
//
// Overview of operation
// - build-out code taken from control bits 7:5
// - codes 0-4 dsx-1 lengths, 5-7 csu attenuation
// - control bit 3 places the jitter attenuator
// - depth bit 2: 0 gives 128, 1 gives 32
// - disable bit 1 bypasses the attenuator
// - power-down bit 0 tri-states both transmit outputs
// - recovery oversamples line sixteen times per bit
// - carrier loss switches recovered clock to master
// - receive-path attenuator restores 50% duty cycle
// - smoothed clock reads data out of fifo
// - detect jitter at fill of 124 or 30 ui and above, or below 4 or 2 ui
// - divide by 15 or 17 on excess jitter
// - set limit-trip flag when dividing off nominal
// - gain-limit bit 4 selects -36 or -30 db
package t1lij_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] T1LIJ_ADDR_LINE_CTL = 8'h7c;
  localparam logic [7:0] T1LIJ_ADDR_RX_INFO = 8'h7d;
  localparam logic [7:0] T1LIJ_ADDR_ISTAT = 8'h7e;
  localparam logic [7:0] T1LIJ_ADDR_IMASK = 8'h7f;
  localparam logic [7:0] T1LIJ_LINE_CTL_RST = 8'h00;
  localparam logic [7:0] T1LIJ_IMASK_RST = 8'h00;
  localparam int T1LIJ_BO_MSB = 7;
  localparam int T1LIJ_BO_LSB = 5;
  localparam int T1LIJ_GAIN_BIT = 4;
  localparam int T1LIJ_PATH_BIT = 3;
  localparam int T1LIJ_DEPTH_BIT = 2;
  localparam int T1LIJ_DIS_BIT = 1;
  localparam int T1LIJ_PDN_BIT = 0;
  localparam int T1LIJ_TRIP_BIT = 5;
  localparam int T1LIJ_CLOS_BIT = 0;
  // ----------------------------------------------------------------
  // timing and fifo
  // ----------------------------------------------------------------
  localparam logic [4:0] T1LIJ_DIV_NOM = 5'd16;
  localparam logic [4:0] T1LIJ_DIV_FAST = 5'd15;
  localparam logic [4:0] T1LIJ_DIV_SLOW = 5'd17;
  localparam logic [3:0] T1LIJ_OVS = 4'hf;
  localparam logic [3:0] T1LIJ_OVS_HALF = 4'h8;
  localparam logic [7:0] T1LIJ_DEPTH_BIG = 8'd128;
  localparam logic [7:0] T1LIJ_DEPTH_SMALL = 8'd32;
  localparam logic [7:0] T1LIJ_MARGIN_BIG = 8'd4;
  localparam logic [7:0] T1LIJ_MARGIN_SMALL = 8'd2;
  localparam logic [5:0] T1LIJ_LOS_ZEROS = 6'd48;
  typedef enum logic [2:0] {T1LIJ_BO_0DB, T1LIJ_BO_266, T1LIJ_BO_399, T1LIJ_BO_533, T1LIJ_BO_655,
                            T1LIJ_BO_CSU75, T1LIJ_BO_CSU15, T1LIJ_BO_CSU225} t1lij_bo_t;
endpackage

/* core/t1lij_recovery.sv */
// clock and data recovery by 16x oversampling of the line pair
// assumes ovs_tick marks each 16x sample instant in the mclk domain
`timescale 1ns/10ps
module t1lij_recovery
  import t1lij_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ovs_tick,
  input wire logic rx_line_pos,
  input wire logic rx_line_neg,
  output logic rec_clk,
  output logic rec_data,
  output logic rec_bit,
  output logic carrier_lost
);
  logic [3:0] phase_r, phase_nxt;
  logic [5:0] zeros_r, zeros_nxt;
  logic clk_r, clk_nxt, data_r, data_nxt, seen_r, seen_nxt, bit_r, bit_nxt;
  logic mark;
  // ----------------------------------------------------------------
  // phase tracking and sampling
  // ----------------------------------------------------------------
  always_comb
  begin
    mark = rx_line_pos | rx_line_neg;
    phase_nxt = phase_r;
    zeros_nxt = zeros_r;
    clk_nxt = clk_r;
    data_nxt = data_r;
    seen_nxt = seen_r;
    bit_nxt = 1'b0;
    if (ovs_tick)
    begin
      phase_nxt = phase_r + 4'h1;
      if (mark)
        seen_nxt = 1'b1;
      if (mark && !seen_r && phase_r > T1LIJ_OVS_HALF)
        phase_nxt = 4'h0;
      clk_nxt = (phase_nxt < T1LIJ_OVS_HALF - 4'h1);
      if (phase_r == T1LIJ_OVS)
      begin
        data_nxt = seen_r | mark;
        bit_nxt = 1'b1;
        seen_nxt = 1'b0;
        if (seen_r | mark)
          zeros_nxt = 6'd0;
        else if (zeros_r != T1LIJ_LOS_ZEROS)
          zeros_nxt = zeros_r + 6'd1;
      end
    end
  end
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      phase_r <= 4'h0;
      zeros_r <= 6'd0;
      clk_r <= 1'b0;
      data_r <= 1'b0;
      seen_r <= 1'b0;
      bit_r <= 1'b0;
    end
    else
    begin
      phase_r <= phase_nxt;
      zeros_r <= zeros_nxt;
      clk_r <= clk_nxt;
      data_r <= data_nxt;
      seen_r <= seen_nxt;
      bit_r <= bit_nxt;
    end
  end
  assign rec_clk = clk_r;
  assign rec_data = data_r;
  assign rec_bit = bit_r;
  assign carrier_lost = (zeros_r == T1LIJ_LOS_ZEROS);
  a_mark_ends_loss: assert property (@(posedge mclk) disable iff (!rst_n)
    rec_bit && rec_data |-> !carrier_lost) else $error("loss flag after a mark");
endmodule

/* core/t1lij_fifo.sv */
// jitter attenuator elastic fifo, 128 bits of flip-flop storage
// assumes write and read strobes are single-cycle pulses in mclk
`timescale 1ns/10ps
module t1lij_fifo
  import t1lij_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic wr_bit,
  input wire logic rd_en,
  output logic rd_bit,
  output logic [7:0] fill
);
  logic [127:0] mem_r, mem_nxt;
  logic [6:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [7:0] fill_r, fill_nxt;
  logic out_r, out_nxt;
  // ----------------------------------------------------------------
  // storage and pointers
  // ----------------------------------------------------------------
  always_comb
  begin
    mem_nxt = mem_r;
    wp_nxt = wp_r;
    rp_nxt = rp_r;
    fill_nxt = fill_r;
    out_nxt = out_r;
    if (wr_en && fill_r != T1LIJ_DEPTH_BIG)
    begin
      mem_nxt[wp_r] = wr_bit;
      wp_nxt = wp_r + 7'd1;
      fill_nxt = fill_nxt + 8'd1;
    end
    if (rd_en && fill_r != 8'd0)
    begin
      out_nxt = mem_r[rp_r];
      rp_nxt = rp_r + 7'd1;
      fill_nxt = fill_nxt - 8'd1;
    end
  end
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mem_r <= '0;
      wp_r <= 7'd0;
      rp_r <= 7'd0;
      fill_r <= 8'd0;
      out_r <= 1'b0;
    end
    else
    begin
      mem_r <= mem_nxt;
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      fill_r <= fill_nxt;
      out_r <= out_nxt;
    end
  end
  assign rd_bit = out_r;
  assign fill = fill_r;
  a_fill_bounded: assert property (@(posedge mclk) disable iff (!rst_n)
    fill_r <= T1LIJ_DEPTH_BIG) else $error("fifo fill above depth");
endmodule

/* testbench/t1lij_line_model.sv */
// line side model: ami marks on the receive pair, one mark per bit
// assumes the line pair is sampled in mclk and a bit lasts bit_cyc mclk periods
`timescale 1ns/10ps
module t1lij_line_model
#(
  parameter int BIT_CYC = 256
)
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic carrier_on,
  output logic rx_line_pos,
  output logic rx_line_neg
);
  // ----------------------------------------------------------------
  // bit timing and alternate mark polarity
  // ----------------------------------------------------------------
  int cnt;
  logic pol;

  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt <= 0;
      pol <= 1'b0;
      rx_line_pos <= 1'b0;
      rx_line_neg <= 1'b0;
    end
    else
    begin
      cnt <= (cnt == BIT_CYC - 1) ? 0 : cnt + 1;
      if (cnt == BIT_CYC - 1)
      begin
        pol <= ~pol;
      end
      // half-width pulse, opposite polarity each bit; idle pair when silent
      rx_line_pos <= carrier_on && (cnt < BIT_CYC / 2) && !pol;
      rx_line_neg <= carrier_on && (cnt < BIT_CYC / 2) && pol;
    end
  end
endmodule

/* testbench/tb_top.sv */
// self-checking bench for the line interface control and jitter block
// assumes the register port and line model; all stimulus on rising mclk
`timescale 1ns/10ps
module tb_top;
  import t1lij_pkg::*;
  logic mclk, rst_n, wr_stb, rd_stb, carrier_on;
  logic [7:0] addr, wdata, rdata, d;
  logic irq, rx_line_pos, rx_line_neg, tx_clock_in, tx_data_in, tx_line_clock_en;
  logic tx_line_pos_o, tx_line_pos_oe, tx_line_neg_o, tx_line_neg_oe;
  logic [2:0] build_out_code;
  logic rx_gain_limit, recovered_clock_out, rx_data_out, tx_line_clock, rx_carrier_loss, prev;
  int n_errors, n_compared, tcnt, edges;

  t1lij_top uut (.mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata), .irq(irq), .rx_line_pos(rx_line_pos), .rx_line_neg(rx_line_neg),
    .tx_clock_in(tx_clock_in), .tx_data_in(tx_data_in), .tx_line_clock_en(tx_line_clock_en),
    .tx_line_pos_o(tx_line_pos_o), .tx_line_pos_oe(tx_line_pos_oe), .tx_line_neg_o(tx_line_neg_o),
    .tx_line_neg_oe(tx_line_neg_oe), .build_out_code(build_out_code), .rx_gain_limit(rx_gain_limit),
    .recovered_clock_out(recovered_clock_out), .rx_data_out(rx_data_out),
    .tx_line_clock(tx_line_clock), .rx_carrier_loss(rx_carrier_loss));

  t1lij_line_model line (.mclk(mclk), .rst_n(rst_n), .carrier_on(carrier_on),
    .rx_line_pos(rx_line_pos), .rx_line_neg(rx_line_neg));

  // ----------------------------------------------------------------
  // clock, gapped transmit clock, watchdog
  // ----------------------------------------------------------------
  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  always @(posedge mclk)
  begin
    tcnt <= (tcnt == 161) ? 0 : tcnt + 1;
    tx_clock_in <= (tcnt < 81) && (tcnt % 2 == 0 || tcnt > 40);
    tx_data_in <= tcnt[3];
  end

  initial
  begin
    repeat (60000) @(posedge mclk);
    n_errors++;
    summarize();
  end

  // ----------------------------------------------------------------
  // register port tasks and compare
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk);
    addr <= a;
    wdata <= v;
    wr_stb <= 1'b1;
    @(posedge mclk);
    wr_stb <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge mclk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge mclk);
    rd_stb <= 1'b0;
    #1;
    v = rdata;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wait_irq(input logic lvl);
    int i;
    for (i = 0; i < 20000 && irq !== lvl; i++)
      @(posedge mclk);
    #1;
  endtask

  task automatic summarize();
    $display("compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial
  begin
    rst_n = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    carrier_on = 1'b1;
    tx_line_clock_en = 1'b1;
    n_errors = 0;
    n_compared = 0;
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    // reset values, unmapped place, read data only one cycle
    rd(T1LIJ_ADDR_LINE_CTL, d);
    chk(d, T1LIJ_LINE_CTL_RST);
    @(posedge mclk);
    #1;
    chk(rdata, 8'h00);
    chk({6'h0, tx_line_pos_oe, tx_line_neg_oe}, 8'h03);
    wr(8'h00, 8'hff);
    rd(8'h00, d);
    chk(d, 8'h00);
    rd(T1LIJ_ADDR_IMASK, d);
    chk(d, T1LIJ_IMASK_RST);
    $display("test reset done");
    // every build-out code, with the gain-limit bit alternating
    for (int i = 0; i < 8; i++)
    begin
      wr(T1LIJ_ADDR_LINE_CTL, {i[2:0], i[0], 4'h0});
      chk({5'h0, build_out_code}, {5'h0, i[2:0]});
      chk({7'h0, rx_gain_limit}, {7'h0, i[0]});
      rd(T1LIJ_ADDR_LINE_CTL, d);
      chk(d, {i[2:0], i[0], 4'h0});
    end
    $display("test build-out done");
    // power down and back
    wr(T1LIJ_ADDR_LINE_CTL, 8'h01);
    chk({6'h0, tx_line_pos_oe, tx_line_neg_oe}, 8'h00);
    chk({6'h0, tx_line_pos_o, tx_line_neg_o}, 8'h00);
    wr(T1LIJ_ADDR_LINE_CTL, 8'h0e);
    chk({6'h0, tx_line_pos_oe, tx_line_neg_oe}, 8'h03);
    rd(T1LIJ_ADDR_LINE_CTL, d);
    chk(d, 8'h0e);
    wr(T1LIJ_ADDR_LINE_CTL, 8'h00);
    $display("test power-down done");
    // recovered clock runs with carrier present
    edges = 0;
    for (int i = 0; i < 2000; i++)
    begin
      prev = recovered_clock_out;
      @(posedge mclk);
      #1;
      edges += (recovered_clock_out !== prev);
    end
    chk({7'h0, edges > 0}, 8'h01);
    // carrier loss: sticky status, mask, level irq, write-one clear
    wr(T1LIJ_ADDR_ISTAT, 8'hff);
    wr(T1LIJ_ADDR_IMASK, 8'h01);
    carrier_on <= 1'b0;
    wait_irq(1'b1);
    chk({7'h0, irq}, 8'h01);
    chk({7'h0, rx_carrier_loss}, 8'h01);
    rd(T1LIJ_ADDR_RX_INFO, d);
    chk({7'h0, d[T1LIJ_CLOS_BIT]}, 8'h01);
    rd(T1LIJ_ADDR_ISTAT, d);
    chk({7'h0, d[T1LIJ_CLOS_BIT]}, 8'h01);
    edges = 0;
    for (int i = 0; i < 2000; i++)
    begin
      prev = recovered_clock_out;
      @(posedge mclk);
      #1;
      edges += (recovered_clock_out !== prev);
    end
    chk({7'h0, edges > 0}, 8'h01);
    wr(T1LIJ_ADDR_IMASK, 8'h00);
    chk({7'h0, irq}, 8'h00);
    wr(T1LIJ_ADDR_IMASK, 8'h01);
    chk({7'h0, irq}, 8'h01);
    wr(T1LIJ_ADDR_ISTAT, 8'h01);
    chk({7'h0, irq}, 8'h00);
    rd(T1LIJ_ADDR_ISTAT, d);
    chk({7'h0, d[T1LIJ_CLOS_BIT]}, 8'h00);
    // carrier returns: live loss flag clears
    carrier_on <= 1'b1;
    for (int i = 0; i < 3000; i++)
    begin
      rd(T1LIJ_ADDR_RX_INFO, d);
      if (d[T1LIJ_CLOS_BIT] === 1'b0)
        break;
    end
    chk({7'h0, d[T1LIJ_CLOS_BIT]}, 8'h00);
    $display("test carrier loss done");
    // attenuator on the transmit side, small depth, gapped clock overfills it
    wr(T1LIJ_ADDR_ISTAT, 8'hff);
    wr(T1LIJ_ADDR_LINE_CTL, 8'h0c);
    edges = 0;
    for (int i = 0; i < 3000; i++)
    begin
      prev = tx_line_clock;
      @(posedge mclk);
      #1;
      edges += (tx_line_clock !== prev);
    end
    chk({7'h0, edges > 0}, 8'h01);
    rd(T1LIJ_ADDR_RX_INFO, d);
    chk({7'h0, d[T1LIJ_TRIP_BIT]}, 8'h01);
    rd(T1LIJ_ADDR_ISTAT, d);
    chk({7'h0, d[T1LIJ_TRIP_BIT]}, 8'h01);
    // bypassed: divide returns to nominal, receive data straight from recovery
    wr(T1LIJ_ADDR_LINE_CTL, 8'h0e);
    repeat (600) @(posedge mclk);
    #1;
    chk({7'h0, rx_data_out}, 8'h01);
    wr(T1LIJ_ADDR_ISTAT, 8'hff);
    rd(T1LIJ_ADDR_RX_INFO, d);
    chk({7'h0, d[T1LIJ_TRIP_BIT]}, 8'h00);
    $display("test jitter attenuator done");
    summarize();
  end
endmodule
